/* File: src/gps_port_strobe.sv */
// general port strobe logic: trigger and data registers, strobe sequencer, pin muxing
// assumes host strobes are synchronous one-cycle pulses and external latches/buffers
`timescale 1ns/100ps
`include "gps_defs.svh"

// Overview of operation
// - input mode latches local lines 7-4 later
// - trigger drives low nibble, pulses strobe write
// - nibble captured at strobe rising edge
// - strobe write pulses only when select 01b
// - system bus select 01b routes port strobe
// - byte read needs read enable bit 2
// - port read strobes buffer onto system lines
// - byte read cycle about 18-20 system clocks
// - output mode drives nibble, strobe falls one clock later
// - strobe rises 2 dclks, data holds half
// - pci upper select drives two static bits
// - system bus 11b drives two static bits
// - system bus 10b one static bit, keeps rom
// - byte output shown on system lines 15-8
// - byte output cycle about 6-8 clocks
// - default select drives shared pins high
module gps_port_strobe
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // configuration
    input wire logic pci_mode,
    input wire logic [1:0] pin_function_select,
    input wire logic [7:0] port_read_enable_register,
    // host register writes
    input wire logic trigger_wr,
    input wire logic [7:0] trigger_wdata,
    input wire logic data_wr,
    input wire logic [7:0] data_wdata,
    // host i/o read cycle
    input wire logic bus_address_strobe,
    input wire logic bus_read_write,
    input wire logic [15:0] bus_io_addr,
    // host visible state
    output logic [7:0] port_trigger_register,
    output logic [7:0] port_data_register,
    output logic [7:0] read_data,
    output logic read_done,
    output logic busy,
    // local data lines
    input wire logic [7:0] local_data_lines_in,
    output logic [3:0] local_data_lines_out,
    output logic local_data_lines_oe,
    // system data lines, upper byte for output, lower byte for input
    input wire logic [7:0] system_data_lines_in,
    output logic [7:0] system_data_lines_out,
    output logic system_data_lines_oe,
    // shared pins
    input wire logic rom_chip_select_n_in,
    output logic strobe_write_pulse_n,
    output logic shared_enable_n,
    output logic rom_select_pin_n
);

    gps_pkg::gps_state_t state_reg; // sequencer state
    logic [4:0] cnt_reg;            // cycles or half ticks in state
    logic half_tick;                // half display clock enable
    logic nib_start;                // nibble sequence start
    logic rd_start;                 // byte read start
    logic wr_start;                 // byte write start
    logic [7:0] sd_out_reg;         // byte driven to external latch
    logic strobe_write_pulse_next;                // next strobe write pin
    logic shared_next;              // next pin 151 level
    logic rom_next;                 // next pin 153 level
    logic [3:0] data_low_reg;       // host written low nibble
    logic [3:0] data_high_reg;      // captured or host written high nibble
    logic [1:0] wr_tail_reg;        // byte write drive kept past the strobe rise

    // select decode used by several processes
    function automatic logic sel_is(input logic [1:0] sel, input logic [1:0] code);
        sel_is = (sel == code);
    endfunction

    // one sequence per access, only while idle with strobe select
    assign nib_start = trigger_wr && pci_mode && !busy
                       && sel_is(pin_function_select, `GPS_SEL_STROBE);
    assign rd_start = bus_address_strobe && bus_read_write && !pci_mode
                      && (bus_io_addr == `GPS_IO_READ_PORT)
                      && port_read_enable_register[`GPS_RDEN_BIT]
                      && !busy
                      && sel_is(pin_function_select, `GPS_SEL_STROBE);
    assign wr_start = trigger_wr && !pci_mode && !busy
                      && sel_is(pin_function_select, `GPS_SEL_STROBE);

    // half display clock divider, phase restarted on each nibble sequence
    gps_half_tick u_tick
    (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clear(nib_start),
        .tick(half_tick)
    );

    // trigger register, any write stores the byte
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            port_trigger_register <= `GPS_TRIG_RST;
        end
        else if (trigger_wr)
        begin
            port_trigger_register <= trigger_wdata;
        end
    end

    // low nibble from host writes
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            data_low_reg <= 4'(`GPS_DATA_RST);
        end
        else if (data_wr)
        begin
            data_low_reg <= data_wdata[3:0];
        end
    end

    // upper nibble: capture at strobe rising edge wins over host write
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            data_high_reg <= 4'(`GPS_DATA_RST >> 4);
        end
        else if ((state_reg == gps_pkg::GPS_NIB_LOW) && half_tick
                 && (cnt_reg == 5'(`GPS_STROBE_WRITE_PULSE_HALVES - 1)))
        begin
            data_high_reg <= local_data_lines_in[7:4];
        end
        else if (data_wr)
        begin
            data_high_reg <= data_wdata[7:4];
        end
    end

    // strobe sequencer
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state_reg <= gps_pkg::GPS_IDLE;
            cnt_reg <= 5'h00;
        end
        else
        begin
            case (state_reg)
                gps_pkg::GPS_IDLE:
                begin
                    cnt_reg <= 5'h00;
                    if (nib_start)
                    begin
                        state_reg <= gps_pkg::GPS_NIB_LOW;
                    end
                    else if (rd_start)
                    begin
                        state_reg <= gps_pkg::GPS_RD_STB;
                    end
                    else if (wr_start)
                    begin
                        state_reg <= gps_pkg::GPS_WR_STB;
                    end
                end
                // strobe low for two display clocks
                gps_pkg::GPS_NIB_LOW:
                begin
                    if (half_tick)
                    begin
                        if (cnt_reg == 5'(`GPS_STROBE_WRITE_PULSE_HALVES - 1))
                        begin
                            state_reg <= gps_pkg::GPS_NIB_HOLD;
                            cnt_reg <= 5'h00;
                        end
                        else
                        begin
                            cnt_reg <= cnt_reg + 5'h01;
                        end
                    end
                end
                // nibble held half a display clock after the edge
                gps_pkg::GPS_NIB_HOLD:
                begin
                    if (half_tick)
                    begin
                        if (cnt_reg == 5'(`GPS_HOLD_HALVES - 1))
                        begin
                            state_reg <= gps_pkg::GPS_IDLE;
                            cnt_reg <= 5'h00;
                        end
                        else
                        begin
                            cnt_reg <= cnt_reg + 5'h01;
                        end
                    end
                end
                // byte read strobe
                gps_pkg::GPS_RD_STB:
                begin
                    if (cnt_reg == 5'(`GPS_RD_SCLKS - 1))
                    begin
                        state_reg <= gps_pkg::GPS_IDLE;
                        cnt_reg <= 5'h00;
                    end
                    else
                    begin
                        cnt_reg <= cnt_reg + 5'h01;
                    end
                end
                // byte write strobe
                gps_pkg::GPS_WR_STB:
                begin
                    if (cnt_reg == 5'(`GPS_WR_SCLKS - 1))
                    begin
                        state_reg <= gps_pkg::GPS_IDLE;
                        cnt_reg <= 5'h00;
                    end
                    else
                    begin
                        cnt_reg <= cnt_reg + 5'h01;
                    end
                end
                default:
                begin
                    state_reg <= gps_pkg::GPS_IDLE;
                    cnt_reg <= 5'h00;
                end
            endcase
        end
    end

    // byte read data captured at the end of the strobe
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            read_data <= 8'h00;
            read_done <= 1'b0;
        end
        else
        begin
            read_done <= 1'b0;
            if ((state_reg == gps_pkg::GPS_RD_STB) && (cnt_reg == 5'(`GPS_RD_SCLKS - 1)))
            begin
                read_data <= system_data_lines_in;
                read_done <= 1'b1;
            end
        end
    end

    // byte presented to the output latch
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            sd_out_reg <= 8'h00;
        end
        else if (wr_start)
        begin
            sd_out_reg <= trigger_wdata;
        end
    end

    // data line drives follow the sequencer state
    // drives held past the registered strobe rise, so the far latch sees stable data
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            local_data_lines_oe <= 1'b0;
            wr_tail_reg <= 2'b00;
        end
        else
        begin
            local_data_lines_oe <= nib_start || (state_reg == gps_pkg::GPS_NIB_LOW)
                                   || (state_reg == gps_pkg::GPS_NIB_HOLD);
            wr_tail_reg <= {wr_tail_reg[0], state_reg == gps_pkg::GPS_WR_STB};
        end
    end

    assign port_data_register = {data_high_reg, data_low_reg};
    assign local_data_lines_out = port_data_register[3:0];
    assign system_data_lines_out = sd_out_reg;
    // byte stays driven through the strobe rise, either edge may latch it
    assign system_data_lines_oe = (state_reg == gps_pkg::GPS_WR_STB)
                                  || (wr_tail_reg != 2'b00);
    assign busy = (state_reg != gps_pkg::GPS_IDLE) || (wr_tail_reg != 2'b00);

    // pin function mux
    always_comb
    begin
        strobe_write_pulse_next = 1'b1;
        shared_next = 1'b1;
        rom_next = 1'b1;
        if (pci_mode)
        begin
            if (pin_function_select[1])
            begin
                shared_next = port_trigger_register[0];
                strobe_write_pulse_next = port_trigger_register[1];
            end
            else if (sel_is(pin_function_select, `GPS_SEL_STROBE))
            begin
                strobe_write_pulse_next = !(state_reg == gps_pkg::GPS_NIB_LOW);
            end
        end
        else
        begin
            case (pin_function_select)
                `GPS_SEL_TWO_BIT:
                begin
                    shared_next = port_trigger_register[0];
                    rom_next = port_trigger_register[1];
                end
                `GPS_SEL_ONE_BIT:
                begin
                    shared_next = port_trigger_register[0];
                    rom_next = rom_chip_select_n_in;
                end
                `GPS_SEL_STROBE:
                begin
                    shared_next = !((state_reg == gps_pkg::GPS_RD_STB)
                                    || (state_reg == gps_pkg::GPS_WR_STB));
                    rom_next = rom_chip_select_n_in;
                end
                default:
                begin
                    shared_next = 1'b1;
                    rom_next = 1'b1;
                end
            endcase
        end
    end

    // registered pins, high from reset
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            strobe_write_pulse_n <= 1'b1;
            shared_enable_n <= 1'b1;
            rom_select_pin_n <= 1'b1;
        end
        else
        begin
            strobe_write_pulse_n <= strobe_write_pulse_next;
            shared_enable_n <= shared_next;
            rom_select_pin_n <= rom_next;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // strobe low phase and rise
    sequence strobe_write_pulse_low_s;
        !strobe_write_pulse_n [*8];
    endsequence
    sequence strobe_write_pulse_rise_s;
        strobe_write_pulse_n;
    endsequence

    trig_store_a: assert property (
        trigger_wr |=> port_trigger_register == $past(trigger_wdata))
        else $error("trigger register not stored");
    nib_drive_a: assert property (
        nib_start |=> local_data_lines_oe && local_data_lines_out == $past(port_data_register[3:0]))
        else $error("nibble not driven on trigger");
    strobe_write_pulse_width_a: assert property (
        nib_start |=> ##1 strobe_write_pulse_low_s ##1 strobe_write_pulse_rise_s)
        else $error("strobe write width wrong");
    nib_capture_a: assert property (
        pci_mode && $rose(strobe_write_pulse_n) && $past(state_reg) == gps_pkg::GPS_NIB_HOLD
        |-> port_data_register[7:4] == $past(local_data_lines_in[7:4], 2))
        else $error("nibble not captured at strobe edge");
    nib_hold_a: assert property (
        $rose(strobe_write_pulse_n) && $past(state_reg) == gps_pkg::GPS_NIB_HOLD
        |-> local_data_lines_oe [*2] ##1 (!local_data_lines_oe || busy))
        else $error("nibble hold time wrong");
    read_cycle_a: assert property (
        rd_start |=> ##1 !shared_enable_n ##17 !shared_enable_n && read_done)
        else $error("byte read cycle length wrong");
    write_cycle_a: assert property (
        wr_start |=> system_data_lines_oe && system_data_lines_out == $past(trigger_wdata)
        ##7 system_data_lines_oe && shared_enable_n ##1 !system_data_lines_oe)
        else $error("byte write cycle wrong");
    pin_default_a: assert property (
        $past(pin_function_select) == `GPS_SEL_IDLE
        |-> shared_enable_n && rom_select_pin_n && strobe_write_pulse_n)
        else $error("default pins not high");
    static_bits_a: assert property (
        !$past(pci_mode) && $past(pin_function_select) == `GPS_SEL_TWO_BIT
        |-> shared_enable_n == $past(port_trigger_register[0])
        && rom_select_pin_n == $past(port_trigger_register[1]))
        else $error("static outputs wrong");
    one_start_a: assert property (
        $rose(busy) |-> $past(pin_function_select) == `GPS_SEL_STROBE)
        else $error("strobe without strobe select");

endmodule

/* File: inc/gps_defs.svh */
// constants of the general port strobe logic: pin selects, field positions, timing
// assumes a 100 MHz ref_clk; the display clock is derived from it by a divider
`ifndef GPS_DEFS_SVH
`define GPS_DEFS_SVH

// pin function select codes
`define GPS_SEL_IDLE 2'b00
`define GPS_SEL_STROBE 2'b01
`define GPS_SEL_ONE_BIT 2'b10
`define GPS_SEL_TWO_BIT 2'b11

// field positions
`define GPS_RDEN_BIT 2
`define GPS_IO_READ_PORT 16'h03C8

// reset values
`define GPS_TRIG_RST 8'h00
`define GPS_DATA_RST 8'h00

// clock periods in ns
`define GPS_REF_CLK_NS 10
`define GPS_DISPLAY_CLOCK_NS 40

// half display clock in ref_clk cycles, at least one
`define GPS_HALF_CYC ((`GPS_DISPLAY_CLOCK_NS / 2 + `GPS_REF_CLK_NS - 1) / `GPS_REF_CLK_NS)

// strobe low for 2 display clocks, data held 1/2 display clock after
`define GPS_STROBE_WRITE_PULSE_DCLKS 2
`define GPS_STROBE_WRITE_PULSE_HALVES (`GPS_STROBE_WRITE_PULSE_DCLKS * 2)
`define GPS_HOLD_HALVES 1

// system bus cycles in system clocks (system clock is ref_clk)
`define GPS_RD_SCLKS 18
`define GPS_WR_SCLKS 6

`endif

/* File: inc/gps_pkg.sv */
// types of the general port strobe logic
// assumes gps_defs.svh supplies all numeric constants
package gps_pkg;

    // sequencer states
    typedef enum logic [2:0]
    {
        GPS_IDLE,
        GPS_NIB_LOW,
        GPS_NIB_HOLD,
        GPS_RD_STB,
        GPS_WR_STB
    } gps_state_t;

endpackage

/* File: src/gps_half_tick.sv */
// half display clock tick divider
// assumes one ref_clk domain; clear restarts the phase
`timescale 1ns/100ps
`include "gps_defs.svh"

module gps_half_tick
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // control
    input wire logic clear,
    // one cycle enable every half display clock
    output logic tick
);

    localparam int unsigned HALF = `GPS_HALF_CYC;

    logic [7:0] cnt_reg; // phase counter

    // count half periods, restart on clear
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || clear)
        begin
            cnt_reg <= 8'h00;
        end
        else if (cnt_reg == 8'(HALF - 1))
        begin
            cnt_reg <= 8'h00;
        end
        else
        begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    // tick at the last count of each half period
    assign tick = (cnt_reg == 8'(HALF - 1)) && !clear;

endmodule

/* File: testbench/gps_far_side.sv */
// far side of the port pins: nibble driver, byte input buffer, byte and nibble latches
// assumes active low enables from the block and a bench that says when to drive the nibble
`timescale 1ns/100ps

module gps_far_side
(
    // clock
    input wire logic ref_clk,
    // bench control
    input wire logic nib_drive,
    input wire logic [3:0] nib_value,
    input wire logic [7:0] byte_value,
    input wire logic bus_read_write,
    // block pins
    input wire logic [3:0] local_data_lines_out,
    input wire logic local_data_lines_oe,
    input wire logic [7:0] system_data_lines_out,
    input wire logic system_data_lines_oe,
    input wire logic strobe_write_pulse_n,
    input wire logic shared_enable_n,
    // lines seen by the block
    output logic [7:0] local_data_lines_in,
    output logic [7:0] system_data_lines_in,
    // captured values
    output logic [7:0] out_latch,
    output logic [3:0] nib_latch
);
    // history of the lines, so released lines change every cycle
    logic [7:0] ld_hist = 8'h00;
    logic [7:0] sd_hist = 8'h00;

    initial
    begin
        out_latch = 8'h00;
        nib_latch = 4'h0;
    end

    always @(posedge ref_clk)
    begin
        ld_hist <= local_data_lines_in;
        sd_hist <= system_data_lines_in;
    end

    // nibble driven only while the bench enables it, else a moving pattern
    assign local_data_lines_in = nib_drive ? {nib_value, local_data_lines_out} : ~ld_hist;

    // input buffer enabled only by a read-qualified strobe
    assign system_data_lines_in = (!shared_enable_n && bus_read_write) ? byte_value
                                                                       : ~sd_hist;

    // output latch takes the byte on the falling edge of a write-qualified strobe
    always @(negedge shared_enable_n)
    begin
        if (!bus_read_write && system_data_lines_oe)
        begin
            out_latch <= system_data_lines_out;
        end
    end

    // nibble latch takes the low nibble on the rising edge of the write strobe
    always @(posedge strobe_write_pulse_n)
    begin
        if (local_data_lines_oe === 1'b1)
        begin
            nib_latch <= local_data_lines_out;
        end
    end
endmodule

/* File: testbench/general_io_port_strobe_logic_tb.sv */
// self-checking bench of the general port strobe logic
// assumes the far side model above and a 100 MHz clock
`timescale 1ns/100ps
`include "gps_defs.svh"

module general_io_port_strobe_logic_tb;
    // stimulus
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic pci_mode = 1'b0;
    logic [1:0] pin_function_select = 2'b00;
    logic [7:0] port_read_enable_register = 8'h00;
    logic trigger_wr = 1'b0;
    logic [7:0] trigger_wdata = 8'h00;
    logic data_wr = 1'b0;
    logic [7:0] data_wdata = 8'h00;
    logic bus_address_strobe = 1'b0;
    logic bus_read_write = 1'b0;
    logic [15:0] bus_io_addr = 16'h0000;
    logic rom_chip_select_n_in = 1'b1;
    logic nib_drive = 1'b0;
    logic [3:0] nib_value = 4'h0;
    logic [7:0] byte_value = 8'h00;
    // observed
    logic [7:0] port_trigger_register, port_data_register, read_data;
    logic read_done, busy, local_data_lines_oe, system_data_lines_oe;
    logic [3:0] local_data_lines_out, nib_latch;
    logic [7:0] local_data_lines_in, system_data_lines_in, system_data_lines_out, out_latch;
    logic strobe_write_pulse_n, shared_enable_n, rom_select_pin_n;
    // monitors and counters
    int err_total = 0;
    int cmp_count = 0;
    int cyc_count = 0;
    int low_190 = 0;
    int low_151 = 0;
    logic oe_at_rise = 1'b0;
    logic [1:0] hist_190 = 2'b11;
    int n;

    gps_port_strobe u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .pci_mode(pci_mode),
        .pin_function_select(pin_function_select),
        .port_read_enable_register(port_read_enable_register),
        .trigger_wr(trigger_wr), .trigger_wdata(trigger_wdata), .data_wr(data_wr),
        .data_wdata(data_wdata), .bus_address_strobe(bus_address_strobe),
        .bus_read_write(bus_read_write), .bus_io_addr(bus_io_addr),
        .port_trigger_register(port_trigger_register), .port_data_register(port_data_register),
        .read_data(read_data), .read_done(read_done), .busy(busy),
        .local_data_lines_in(local_data_lines_in), .local_data_lines_out(local_data_lines_out),
        .local_data_lines_oe(local_data_lines_oe), .system_data_lines_in(system_data_lines_in),
        .system_data_lines_out(system_data_lines_out),
        .system_data_lines_oe(system_data_lines_oe), .rom_chip_select_n_in(rom_chip_select_n_in),
        .strobe_write_pulse_n(strobe_write_pulse_n), .shared_enable_n(shared_enable_n),
        .rom_select_pin_n(rom_select_pin_n));

    gps_far_side u_far (.ref_clk(ref_clk), .nib_drive(nib_drive), .nib_value(nib_value),
        .byte_value(byte_value), .bus_read_write(bus_read_write),
        .local_data_lines_out(local_data_lines_out), .local_data_lines_oe(local_data_lines_oe),
        .system_data_lines_out(system_data_lines_out),
        .system_data_lines_oe(system_data_lines_oe), .strobe_write_pulse_n(strobe_write_pulse_n),
        .shared_enable_n(shared_enable_n), .local_data_lines_in(local_data_lines_in),
        .system_data_lines_in(system_data_lines_in), .out_latch(out_latch),
        .nib_latch(nib_latch));

    // 100 MHz clock
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end

    // pin activity monitor and hang guard
    always @(posedge ref_clk)
    begin
        cyc_count <= cyc_count + 1;
        if (strobe_write_pulse_n === 1'b0) low_190 <= low_190 + 1;
        if (shared_enable_n === 1'b0) low_151 <= low_151 + 1;
        // nibble drive one cycle after the strobe rise
        if (hist_190 === 2'b01 && strobe_write_pulse_n === 1'b1) oe_at_rise <= local_data_lines_oe;
        hist_190 <= {hist_190[0], strobe_write_pulse_n};
        if (cyc_count > 6000)
        begin
            err_total = err_total + 1;
            end_of_test();
        end
    end

    // one comparison of a value
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // host writes of the trigger and data registers
    task automatic wr_trig(input logic [7:0] v);
        @(negedge ref_clk) trigger_wr = 1'b1;
        trigger_wdata = v;
        @(negedge ref_clk) trigger_wr = 1'b0;
    endtask

    task automatic wr_data(input logic [7:0] v);
        @(negedge ref_clk) data_wr = 1'b1;
        data_wdata = v;
        @(negedge ref_clk) data_wr = 1'b0;
    endtask

    // host i/o read; n holds cycles to read_done, 40 when none came
    task automatic bus_rd(input logic [15:0] addr);
        @(negedge ref_clk) bus_address_strobe = 1'b1;
        bus_io_addr = addr;
        bus_read_write = 1'b1;
        @(negedge ref_clk) bus_address_strobe = 1'b0;
        n = 1;
        while (read_done !== 1'b1 && n < 40)
        begin
            @(posedge ref_clk) #1 n = n + 1;
        end
        repeat (4) @(negedge ref_clk);
    endtask

    // wait for the sequencer to go idle, bounded
    task automatic wait_idle();
        n = 0;
        do
        begin
            @(negedge ref_clk) n = n + 1;
        end
        while (busy !== 1'b0 && n < 50);
        repeat (2) @(negedge ref_clk);
    endtask

    task automatic clr_mon();
        @(negedge ref_clk) low_190 = 0;
        low_151 = 0;
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (12) @(negedge ref_clk);
        sys_rst = 1'b0;
        @(negedge ref_clk);
        // power-up pin states
        chk("pins", 16'h0007, {strobe_write_pulse_n, shared_enable_n, rom_select_pin_n});
        chk("oe", 16'h0000, {local_data_lines_oe, system_data_lines_oe});
        $display("test reset done");
        // nibble strobe, second trigger while busy refused
        pci_mode = 1'b1;
        clr_mon();
        wr_trig(8'h00);
        repeat (12) @(negedge ref_clk);
        chk("idle strobe", 16'h0000, low_190[15:0]);
        pin_function_select = 2'b01;
        wr_data(8'h05);
        nib_drive = 1'b1;
        nib_value = 4'hA;
        clr_mon();
        wr_trig(8'h3C);
        wr_trig(8'h11);
        wait_idle();
        nib_drive = 1'b0;
        chk("data reg", 16'h00A5, {8'h00, port_data_register});
        chk("nibble latch", 16'h0005, {12'h000, nib_latch});
        chk("strobe low", 16'h0008, low_190[15:0]);
        chk("oe after rise", 16'h0001, {15'h0000, oe_at_rise});
        $display("test nibble done");
        // pci static two-bit output
        pin_function_select = 2'b11;
        wr_trig(8'h02);
        @(negedge ref_clk);
        chk("pci static", 16'h0002, {14'h0000, strobe_write_pulse_n, shared_enable_n});
        wr_trig(8'h01);
        @(negedge ref_clk);
        chk("pci static", 16'h0001, {14'h0000, strobe_write_pulse_n, shared_enable_n});
        $display("test pci static done");
        // system bus two-bit and one-bit output
        pci_mode = 1'b0;
        wr_trig(8'h02);
        @(negedge ref_clk);
        chk("sys static", 16'h0001, {14'h0000, shared_enable_n, rom_select_pin_n});
        wr_trig(8'h01);
        @(negedge ref_clk);
        chk("sys static", 16'h0002, {14'h0000, shared_enable_n, rom_select_pin_n});
        pin_function_select = 2'b10;
        rom_chip_select_n_in = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk("one bit", 16'h0002, {14'h0000, shared_enable_n, rom_select_pin_n});
        rom_chip_select_n_in = 1'b1;
        wr_trig(8'h00);
        @(negedge ref_clk);
        chk("one bit", 16'h0001, {14'h0000, shared_enable_n, rom_select_pin_n});
        $display("test sys static done");
        // byte read, enabled then disabled
        pin_function_select = 2'b01;
        port_read_enable_register = 8'h04;
        byte_value = 8'h96;
        clr_mon();
        bus_rd(`GPS_IO_READ_PORT);
        chk("read cycles", 16'd19, n[15:0]);
        chk("read data", 16'h0096, {8'h00, read_data});
        chk("read strobe", 16'd18, low_151[15:0]);
        port_read_enable_register = 8'h00;
        byte_value = 8'h5A;
        clr_mon();
        bus_rd(`GPS_IO_READ_PORT);
        chk("no read", 16'd40, n[15:0]);
        chk("no strobe", 16'h0000, low_151[15:0]);
        $display("test byte read done");
        // byte write on the system bus
        bus_read_write = 1'b0;
        clr_mon();
        wr_trig(8'hC3);
        wait_idle();
        chk("out latch", 16'h00C3, {8'h00, out_latch});
        chk("write strobe", 16'd6, low_151[15:0]);
        chk("no nibble strobe", 16'h0000, low_190[15:0]);
        $display("test byte write done");
        end_of_test();
    end
endmodule
